// ### hdl/hwcur_ctrl.sv
// Cursor and icon overlay control with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "hwcur_params.svh"

// What this block does
// RQ1: Hold X; apply with Y on Y write
// RQ2: Position low bits from index 7:5
// RQ3: Index bits 4:0 select position register
// RQ4: Fine-position MSB from extension bit 0 for the cursor, icon 0 control bit 6 for icons
// RQ5: Control bit 1 opens extra palette entries
// RQ6: Control bit 2 picks 32 or 64 size
// RQ7: Control bit 3 routes cursor or icon
// RQ8: Control bit 0 enables cursor display
// RQ9: 32x32 mode uses pattern bits 4:0
// RQ10: 64x64 mode uses pattern bits 4:2
// RQ11: 32x32 pattern is two 128-byte planes
// RQ12: 64x64 pattern interleaves planes per line
// RQ13: Cursor top 8K, icons next 8K
// RQ14: Software sets map config bit 4 first
// RQ15: Cursor area blocks from 3F800 upward
// RQ16: Icon pixel two bits, four colours
// RQ17: Icon colours from extra entries 03h-06h
// RQ18: Cursor above icons above display
// RQ19: Icons 64x64, each axis doubles
// RQ20: Hot spot; icons stacked left-aligned
// RQ21: Per-icon enable, mode, blink, doubling, map
// RQ22: Eight maps: pairs or all icon 0
module hwcur_ctrl #(
  parameter int POS_W = 11
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  input  wire logic [POS_W-1:0]  scr_x,
  input  wire logic [POS_W-1:0]  scr_y,
  input  wire logic              blink_phase,
  input  wire logic              blink_half_phase,
  input  wire logic [7:0]        display_index,
  input  wire logic              cursor_b0,
  input  wire logic              cursor_b1,
  input  wire logic              icon_b0,
  input  wire logic              icon_b1,
  output logic                   palette_extra_access,
  output logic                   cursor_size64,
  output logic [POS_W-1:0]       cursor_x,
  output logic [POS_W-1:0]       cursor_y,
  output logic                   cursor_fine_msb,
  output logic [POS_W-1:0]       icon_x,
  output logic [POS_W-1:0]       icon_y,
  output logic                   icon_fine_msb,
  output logic [17:0]            cursor_addr_b0,
  output logic [17:0]            cursor_addr_b1,
  output logic [17:0]            icon_addr_b0,
  output logic [17:0]            icon_addr_b1,
  output logic [7:0]             pix_index,
  output logic                   pix_extra,
  output logic                   pix_invert
);

  hwcur_pkg::hwcur_state_t st;
  hwcur_pkg::hwcur_state_t next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_span(input logic [POS_W-1:0] pos,
                                   input logic [POS_W-1:0] start,
                                   input logic [POS_W:0]   len);
    logic [POS_W:0] d;
    d = {1'b0, pos} - {1'b0, start};
    in_span = (pos >= start) && (d < len);
  endfunction : in_span

  function automatic logic [POS_W-1:0] offset(input logic [POS_W-1:0] pos,
                                              input logic [POS_W-1:0] start);
    offset = pos - start;
  endfunction : offset

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_acc;
  logic hit_index;
  logic hit_data;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign pready    = 1'b1;
  assign setup_ph  = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign hit_index = (paddr == `HWCUR_APB_INDEX_OFS);
  assign hit_data  = (paddr == `HWCUR_APB_DATA_OFS);
  assign pslverr   = psel && penable && !(hit_index || hit_data);
  assign wbyte     = pwdata[7:0];

  // Readback of the indexed register under the current index
  always_comb
  begin
    rd_byte = 8'h00;
    if (st.idx[4:0] == `HWCUR_IDX_XPOS)
    begin
      rd_byte = st.ovl[`HWCUR_OVL_ICON_MOVE] ? st.ico_x[10:3] : st.cur_x[10:3];
    end
    else if (st.idx[4:0] == `HWCUR_IDX_YPOS)
    begin
      rd_byte = st.ovl[`HWCUR_OVL_ICON_MOVE] ? st.ico_y[10:3] : st.cur_y[10:3];
    end
    else if (st.idx == `HWCUR_IDX_OVL_CTL)
    begin
      rd_byte = st.ovl;
    end
    else if (st.idx == `HWCUR_IDX_PAT_SEL)
    begin
      rd_byte = st.pat;
    end
    else if (st.idx == `HWCUR_IDX_MAP_CFG)
    begin
      rd_byte = st.mapc;
    end
    else if (st.idx == `HWCUR_IDX_FINE_EXT)
    begin
      rd_byte = st.fext;
    end
    else if (st.idx >= `HWCUR_IDX_ICON0_CTL && st.idx <= `HWCUR_IDX_ICON3_CTL)
    begin
      rd_byte = st.ictl[st.idx[1:0] - 2'd2];
    end
  end

  // ----------------------------------------------------------------
  // Cursor geometry and pattern addressing
  // ----------------------------------------------------------------
  logic            size64;
  logic [POS_W:0]  cur_len;
  logic            cur_hit;
  logic [POS_W-1:0] cur_lx;
  logic [POS_W-1:0] cur_ly;
  logic [17:0]     cur_base;
  logic [17:0]     cur_row0;

  assign size64  = st.ovl[`HWCUR_OVL_SIZE64];
  assign cur_len = size64 ? (POS_W+1)'(64) : (POS_W+1)'(32);
  assign cur_hit = in_span(scr_x, st.cur_x, cur_len) && in_span(scr_y, st.cur_y, cur_len);
  assign cur_lx  = offset(scr_x, st.cur_x);
  assign cur_ly  = offset(scr_y, st.cur_y);

  always_comb
  begin
    if (size64)
    begin
      cur_base = `HWCUR_CURSOR_BASE + 18'(st.pat[4:2]) * `HWCUR_PAT64_WORDS; // RQ10 RQ15
      cur_row0 = cur_base + 18'({cur_ly[5:0], 2'b00}) + 18'(cur_lx[5]);      // RQ12
    end
    else
    begin
      cur_base = `HWCUR_CURSOR_BASE + 18'(st.pat[4:0]) * `HWCUR_PAT32_WORDS; // RQ9 RQ15
      cur_row0 = cur_base + 18'(cur_ly[4:0]);                               // RQ11
    end
  end

  // ----------------------------------------------------------------
  // Icon stack geometry and map addressing
  // ----------------------------------------------------------------
  logic            eight_maps;
  logic [3:0]      ico_hit;
  logic [1:0]      ico_num;
  logic            ico_any;
  logic [POS_W-1:0] ico_top [4];
  logic [POS_W:0]   ico_w   [4];
  logic [POS_W:0]   ico_h   [4];
  logic [POS_W-1:0] ico_lx;
  logic [POS_W-1:0] ico_ly;
  logic [2:0]      ico_map;
  logic [17:0]     ico_row;

  assign eight_maps = (st.fext[2:1] != 2'b00); // RQ22

  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      ico_w[n] = st.ictl[n][`HWCUR_ICN_DBL_H] ? (POS_W+1)'(128) : (POS_W+1)'(64); // RQ19
      ico_h[n] = st.ictl[n][`HWCUR_ICN_DBL_V] ? (POS_W+1)'(128) : (POS_W+1)'(64); // RQ19
    end
    ico_top[0] = st.ico_y;                                                         // RQ20
    for (int n = 1; n < 4; n++)
    begin
      ico_top[n] = ico_top[n-1] + ico_h[n-1][POS_W-1:0];                           // RQ20
    end
    for (int n = 0; n < 4; n++)
    begin
      ico_hit[n] = st.ictl[n][`HWCUR_ICN_ENABLE]
                   && !(eight_maps && n != 0)                                       // RQ22
                   && in_span(scr_x, st.ico_x, ico_w[n])
                   && in_span(scr_y, ico_top[n], ico_h[n]);                         // RQ21
    end
    ico_any = |ico_hit;
    ico_num = 2'd0;
    for (int n = 3; n >= 0; n--)
    begin
      if (ico_hit[n])
      begin
        ico_num = 2'(n);
      end
    end
  end

  always_comb
  begin
    ico_lx = offset(scr_x, st.ico_x) >> st.ictl[ico_num][`HWCUR_ICN_DBL_H];
    ico_ly = offset(scr_y, ico_top[ico_num]) >> st.ictl[ico_num][`HWCUR_ICN_DBL_V];
    if (ico_num == 2'd0 && eight_maps)
    begin
      ico_map = {st.fext[2:1], st.ictl[0][`HWCUR_ICN_MAP_SEL]};  // RQ22
    end
    else
    begin
      ico_map = {ico_num, st.ictl[ico_num][`HWCUR_ICN_MAP_SEL]}; // RQ21 RQ22
    end
    ico_row = `HWCUR_ICON_BASE + 18'(ico_map) * `HWCUR_ICON_MAP_WORDS
              + 18'({ico_ly[5:0], 2'b00}) + 18'(ico_lx[5]);      // RQ13
  end

  // ----------------------------------------------------------------
  // Pixel priority and colour selection
  // ----------------------------------------------------------------
  logic       ico_blank;
  logic [7:0] mix_index;
  logic       mix_extra;
  logic       mix_invert;
  logic [1:0] ico_code;

  assign ico_code = {icon_b0, icon_b1};

  always_comb
  begin
    ico_blank = 1'b0;
    if (st.ictl[ico_num][`HWCUR_ICN_BLINK])
    begin
      ico_blank = st.ictl[ico_num][`HWCUR_ICN_HALF_RATE] ? !blink_half_phase : !blink_phase;
    end
    mix_index  = display_index;
    mix_extra  = 1'b0;
    mix_invert = 1'b0;
    if (ico_any && !ico_blank)
    begin
      if (!(ico_code == 2'b00 && st.ictl[ico_num][`HWCUR_ICN_THREE_COLOUR]))
      begin
        // Bit 1 alone is colour 1, bit 0 alone is colour 2
        mix_index = `HWCUR_ICON_COLOUR0_IDX + 8'({icon_b0, icon_b1}); // RQ16 RQ17
        mix_extra = 1'b1;                                             // RQ17
      end
    end
    if (st.ovl[`HWCUR_OVL_ENABLE] && cur_hit)                         // RQ8
    begin
      unique case ({cursor_b0, cursor_b1})                            // RQ18
        2'b00:
        begin
          mix_invert = 1'b0;
        end
        2'b01:
        begin
          mix_index  = display_index;
          mix_extra  = 1'b0;
          mix_invert = 1'b1;
        end
        2'b10:
        begin
          mix_index = `HWCUR_CUR_COLOUR0_IDX;
          mix_extra = 1'b1;
        end
        2'b11:
        begin
          mix_index = `HWCUR_CUR_COLOUR1_IDX;
          mix_extra = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (setup_ph && !pwrite)
    begin
      next_st.prdata = hit_index ? {24'h000000, st.idx}
                     : hit_data  ? {24'h000000, rd_byte} : 32'h00000000;
    end
    if (wr_acc && hit_index)
    begin
      next_st.idx = wbyte;
    end
    if (wr_acc && hit_data)
    begin
      if (st.idx[4:0] == `HWCUR_IDX_XPOS)                             // RQ3
      begin
        next_st.hold_x    = {wbyte, st.idx[7:5]};                     // RQ1 RQ2
        next_st.hold_fine = st.ovl[`HWCUR_OVL_ICON_MOVE]
                            ? st.ictl[0][`HWCUR_ICN_FINE_MSB]
                            : st.fext[`HWCUR_FINE_EXT_BIT];           // RQ4
      end
      else if (st.idx[4:0] == `HWCUR_IDX_YPOS)                        // RQ3
      begin
        if (st.ovl[`HWCUR_OVL_ICON_MOVE])                             // RQ7
        begin
          next_st.ico_x    = st.hold_x;                               // RQ1
          next_st.ico_fine = st.hold_fine;
          next_st.ico_y    = {wbyte, st.idx[7:5]};                    // RQ2
        end
        else
        begin
          next_st.cur_x    = st.hold_x;                               // RQ1
          next_st.cur_fine = st.hold_fine;                            // RQ4
          next_st.cur_y    = {wbyte, st.idx[7:5]};                    // RQ2
        end
      end
      else if (st.idx == `HWCUR_IDX_OVL_CTL)
      begin
        next_st.ovl = wbyte;
      end
      else if (st.idx == `HWCUR_IDX_PAT_SEL)
      begin
        next_st.pat = wbyte;
      end
      else if (st.idx == `HWCUR_IDX_MAP_CFG)
      begin
        next_st.mapc = wbyte;
      end
      else if (st.idx == `HWCUR_IDX_FINE_EXT)
      begin
        next_st.fext = wbyte;
      end
      else if (st.idx >= `HWCUR_IDX_ICON0_CTL && st.idx <= `HWCUR_IDX_ICON3_CTL)
      begin
        next_st.ictl[st.idx[1:0] - 2'd2] = wbyte;
      end
    end
    next_st.cur_a0     = cur_row0;
    next_st.cur_a1     = size64 ? cur_row0 + 18'd2 : cur_row0 + `HWCUR_PLANE32_WORDS; // RQ11 RQ12
    next_st.ico_a1     = ico_row;
    next_st.ico_a0     = ico_row + 18'd2;
    next_st.pix_index  = mix_index;
    next_st.pix_extra  = mix_extra;
    next_st.pix_invert = mix_invert;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata               = st.prdata;
  assign palette_extra_access = st.ovl[`HWCUR_OVL_PAL_ACCESS]; // RQ5
  assign cursor_size64        = size64;                        // RQ6
  assign cursor_x             = st.cur_x;
  assign cursor_y             = st.cur_y;
  assign cursor_fine_msb      = st.cur_fine;
  assign icon_x               = st.ico_x;
  assign icon_y               = st.ico_y;
  assign icon_fine_msb        = st.ico_fine;
  assign cursor_addr_b0       = st.cur_a0;
  assign cursor_addr_b1       = st.cur_a1;
  assign icon_addr_b0         = st.ico_a0;
  assign icon_addr_b1         = st.ico_a1;
  assign pix_index            = st.pix_index;
  assign pix_extra            = st.pix_extra;
  assign pix_invert           = st.pix_invert;

endmodule : hwcur_ctrl

`default_nettype wire

// ### hdl/hwcur_params.svh
// Constants for the cursor and icon overlay control block
`ifndef HWCUR_PARAMS_SVH
`define HWCUR_PARAMS_SVH

// APB byte offsets
`define HWCUR_APB_INDEX_OFS      12'h000
`define HWCUR_APB_DATA_OFS       12'h004

// Indexed registers
`define HWCUR_IDX_XPOS           5'h10
`define HWCUR_IDX_YPOS           5'h11
`define HWCUR_IDX_OVL_CTL        8'h12
`define HWCUR_IDX_PAT_SEL        8'h13
`define HWCUR_IDX_MAP_CFG        8'h21
`define HWCUR_IDX_ICON0_CTL      8'h2a
`define HWCUR_IDX_ICON3_CTL      8'h2d
`define HWCUR_IDX_FINE_EXT       8'h2e

// Overlay control bits
`define HWCUR_OVL_ENABLE         0
`define HWCUR_OVL_PAL_ACCESS     1
`define HWCUR_OVL_SIZE64         2
`define HWCUR_OVL_ICON_MOVE      3

// Icon control bits
`define HWCUR_ICN_ENABLE         0
`define HWCUR_ICN_THREE_COLOUR   1
`define HWCUR_ICN_BLINK          2
`define HWCUR_ICN_DBL_H          3
`define HWCUR_ICN_DBL_V          4
`define HWCUR_ICN_MAP_SEL        5
`define HWCUR_ICN_FINE_MSB       6
`define HWCUR_ICN_HALF_RATE      7

// Other bits
`define HWCUR_FINE_EXT_BIT       0
`define HWCUR_MAP_CFG_64         4

// Display memory word addresses
`define HWCUR_CURSOR_BASE        18'h3f800
`define HWCUR_ICON_BASE          18'h3f000
`define HWCUR_PAT32_WORDS        18'h00040
`define HWCUR_PAT64_WORDS        18'h00100
`define HWCUR_PLANE32_WORDS      18'h00020
`define HWCUR_ICON_MAP_WORDS     18'h00100

// Extra palette entries
`define HWCUR_CUR_COLOUR0_IDX    8'h00
`define HWCUR_CUR_COLOUR1_IDX    8'h0f
`define HWCUR_ICON_COLOUR0_IDX   8'h03

// Reset values
`define HWCUR_RST_BYTE           8'h00
`define HWCUR_RST_POS            11'h000

`endif

// ### hdl/hwcur_pkg.sv
// Types for the cursor and icon overlay control block
package hwcur_pkg;

  typedef struct packed {
    logic [7:0]       idx;
    logic [7:0]       ovl;
    logic [7:0]       pat;
    logic [7:0]       mapc;
    logic [7:0]       fext;
    logic [3:0][7:0]  ictl;
    logic [10:0]      hold_x;
    logic             hold_fine;
    logic [10:0]      cur_x;
    logic [10:0]      cur_y;
    logic             cur_fine;
    logic [10:0]      ico_x;
    logic [10:0]      ico_y;
    logic             ico_fine;
    logic [31:0]      prdata;
    logic [7:0]       pix_index;
    logic             pix_extra;
    logic             pix_invert;
    logic [17:0]      cur_a0;
    logic [17:0]      cur_a1;
    logic [17:0]      ico_a0;
    logic [17:0]      ico_a1;
  } hwcur_state_t;

endpackage : hwcur_pkg

// ### verification/hwcur_ctrl_chk.sv
// Assertion checker for the cursor and icon overlay control block
`timescale 1ns/100ps
`default_nettype none
module hwcur_ctrl_chk #(
  parameter int POS_W = 11
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pslverr,
  input wire logic [7:0]       display_index,
  input wire logic             cursor_b0,
  input wire logic             cursor_b1,
  input wire logic             palette_extra_access,
  input wire logic             cursor_size64,
  input wire logic [POS_W-1:0] cursor_x,
  input wire logic [POS_W-1:0] cursor_y,
  input wire logic [POS_W-1:0] icon_x,
  input wire logic [POS_W-1:0] icon_y,
  input wire logic [17:0]      cursor_addr_b0,
  input wire logic [17:0]      icon_addr_b0,
  input wire logic [7:0]       pix_index,
  input wire logic             pix_extra,
  input wire logic             pix_invert
);
  logic [7:0] idx_q, ovl_q, wbyte;
  logic [2:0] idx_lo;
  logic       dwr, cur_on;
  assign dwr = psel && penable && pwrite && paddr == 12'h004;
  assign cur_on = ovl_q[0] && cursor_b0;
  assign wbyte = pwdata[7:0];
  assign idx_lo = idx_q[7:5];
  // Shadow of the index and overlay control written by the host
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_q <= 8'h00;
      ovl_q <= 8'h00;
    end
    else if (psel && penable && pwrite && paddr == 12'h000)
      idx_q <= wbyte;
    else if (dwr && idx_q == 8'h12)
      ovl_q <= wbyte;
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence x_write;
    dwr && idx_q[4:0] == 5'h10;
  endsequence
  sequence y_write;
    dwr && idx_q[4:0] == 5'h11;
  endsequence
  a_x_held: assert property (x_write |=> $stable(cursor_x) && $stable(icon_x))
    else $error("x position applied early");
  a_pos_quiet: assert property (!$past(dwr) |-> $stable({cursor_x, cursor_y, icon_x, icon_y}))
    else $error("position moved without a data write");
  a_y_cursor: assert property ((y_write and !ovl_q[3]) |=>
    cursor_y == {$past(wbyte), $past(idx_lo)})
    else $error("cursor y not applied");
  a_y_icon: assert property ((y_write and ovl_q[3]) |=>
    icon_y == {$past(wbyte), $past(idx_lo)})
    else $error("icon y not applied");
  a_pal_access: assert property (palette_extra_access == ovl_q[1])
    else $error("palette access differs from control");
  a_size_sel: assert property (cursor_size64 == ovl_q[2])
    else $error("cursor size differs from control");
  a_cursor_code: assert property (pix_extra && pix_index inside {8'h00, 8'h0f} |->
    $past(cur_on) && pix_index[0] == $past(cursor_b1))
    else $error("cursor colour without cursor");
  a_invert_src: assert property (pix_invert |-> $past(ovl_q[0]) && !$past(cursor_b0) &&
    $past(cursor_b1) && pix_index == $past(display_index))
    else $error("invert without cursor code");
  a_plain_pass: assert property ($past(presetn) && !pix_extra && !pix_invert |->
    pix_index == $past(display_index))
    else $error("display index not passed");
  a_addr_area: assert property ($past(presetn) |-> cursor_addr_b0 >= 18'h3f800 &&
    icon_addr_b0 inside {[18'h3f000:18'h3f7ff]})
    else $error("pattern address outside its area");
  a_slverr_map: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004}))
    else $error("error response wrong");
endmodule : hwcur_ctrl_chk

bind hwcur_ctrl hwcur_ctrl_chk #(.POS_W(POS_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .display_index,
  .cursor_b0, .cursor_b1, .palette_extra_access, .cursor_size64, .cursor_x, .cursor_y,
  .icon_x, .icon_y, .cursor_addr_b0, .icon_addr_b0, .pix_index, .pix_extra, .pix_invert
);
`default_nettype wire

// ### verification/hwcur_ctrl_tb.sv
// Self-checking bench for the cursor and icon overlay control block
`timescale 1ns/100ps
`default_nettype none
module hwcur_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [10:0] scr_x, scr_y, cursor_x, cursor_y, icon_x, icon_y;
  logic        blink_phase, blink_half_phase, cursor_b0, cursor_b1, icon_b0, icon_b1;
  logic [7:0]  display_index, pix_index;
  logic        palette_extra_access, cursor_size64, cursor_fine_msb, icon_fine_msb;
  logic [17:0] cursor_addr_b0, cursor_addr_b1, icon_addr_b0, icon_addr_b1;
  logic        pix_extra, pix_invert;
  logic [10:0] px [2];
  logic [10:0] py [2];
  logic        pf [2];
  int          n_fail, total_checks, seed;

  hwcur_host host (
    .pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata
  );
  hwcur_ctrl #(
    .POS_W(11)
  ) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .scr_x, .scr_y, .blink_phase, .blink_half_phase, .display_index, .cursor_b0, .cursor_b1,
    .icon_b0, .icon_b1, .palette_extra_access, .cursor_size64, .cursor_x, .cursor_y,
    .cursor_fine_msb, .icon_x, .icon_y, .icon_fine_msb, .cursor_addr_b0, .cursor_addr_b1,
    .icon_addr_b0, .icon_addr_b1, .pix_index, .pix_extra, .pix_invert
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    stop_test(1'b1);
  end

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [35:0] x, input logic [35:0] g);
    total_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic stop_test(input logic hang);
    if (hang)
      n_fail++;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic rg(input logic [7:0] i, input logic [7:0] d);
    host.xfer(1'b1, 12'h000, {24'h0, i}, q, e);
    host.xfer(1'b1, 12'h004, {24'h0, d}, q, e);
  endtask : rg
  task automatic pos(input logic t, input logic [10:0] x, input logic [10:0] y, input logic f);
    rg(8'h12, {4'h0, t, 3'h0});
    if (t)
      rg(8'h2a, {1'b0, f, 6'h00});
    else
      rg(8'h2e, {7'h00, f});
    rg({x[2:0], 5'h10}, x[10:3]);
    chk("x_held", px[t], t ? icon_x : cursor_x);
    rg({y[2:0], 5'h11}, y[10:3]);
    px[t] = x;
    py[t] = y;
    pf[t] = f;
    chk("cur_x", px[0], cursor_x);
    chk("cur_y", py[0], cursor_y);
    chk("cur_f", pf[0], cursor_fine_msb);
    chk("ico_x", px[1], icon_x);
    chk("ico_y", py[1], icon_y);
    chk("ico_f", pf[1], icon_fine_msb);
  endtask : pos
  function automatic logic [9:0] exp_pix(input logic [31:0] r);
    if (r[0] && r[3])
      return {2'b10, r[4] ? 8'h0f : 8'h00};
    if (r[0] && r[4])
      return {2'b01, r[15:8]};
    if (r[2] && !(r[17] ? r[16] : r[7]) || r[1] && !r[5] && !r[6])
      return {2'b00, r[15:8]};
    return {2'b10, 8'h03 + {6'h00, r[5], r[6]}};
  endfunction : exp_pix
  function automatic logic [35:0] exp_addr(input logic [31:0] r);
    logic [17:0] a;
    logic [5:0]  rw;
    rw = r[11:6] & {r[0], 5'h1f};
    if (r[0])
      a = 18'h3f800 + {r[5:3], 8'h00} + {rw, 2'h0};
    else
      a = 18'h3f800 + {r[5:1], 6'h00} + rw;
    return {a, a + (r[0] ? 18'h00002 : 18'h00020)};
  endfunction : exp_addr
  function automatic logic [35:0] exp_icon(input logic [31:0] r);
    logic [17:0] a;
    logic [5:0]  rw;
    rw = (r[11:6] & {r[0], 5'h1f}) >> r[14];
    a = 18'h3f000 + {r[16:15], r[12], 8'h00} + {rw, 2'h0};
    return {a + 18'h00002, a};
  endfunction : exp_icon

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'he6fc7adc;
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    {scr_x, scr_y, display_index} = 30'h0;
    {blink_phase, blink_half_phase, cursor_b0, cursor_b1, icon_b0, icon_b1} = 6'h0;
    px = '{11'h000, 11'h000};
    py = '{11'h000, 11'h000};
    pf = '{1'b0, 1'b0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    host.xfer(1'b0, 12'h008, 32'h0, q, e);
    chk("slverr", 36'h1, e);
    chk("pready", 36'h1, pready);
    rg(8'h21, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      rg(8'h12, {5'h00, i[1:0], 1'b0});
      chk("pal", i[0], palette_extra_access);
      chk("size", i[1], cursor_size64);
    end
    host.xfer(1'b0, 12'h004, 32'h0, q, e);
    chk("ovl_rd", 36'h6, {e, q});
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      pos(r[0], r[11:1], r[22:12], r[23]);
    end
    $display("position test done");
    pos(1'b0, 11'h064, 11'h0c8, 1'b0);
    pos(1'b1, 11'h064, 11'h0c8, 1'b0);
    for (int i = 0; i < 48; i++)
    begin
      r = $random(seed);
      rg(8'h12, {7'h00, r[0]});
      rg(8'h2a, {r[17], 4'h0, r[2:1], 1'b1});
      {cursor_b0, cursor_b1, icon_b0, icon_b1} <= {r[3], r[4], r[5], r[6]};
      {blink_half_phase, display_index, blink_phase} <= r[16:7];
      scr_x <= 11'h066;
      scr_y <= 11'h0ca;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("pix", exp_pix(r), {pix_extra, pix_invert, pix_index});
      @(posedge pclk);
    end
    $display("pixel test done");
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      rg(8'h12, {5'h00, r[0], 2'h1});
      rg(8'h13, {3'h0, r[5:1]});
      rg(8'h2a, {2'h0, r[12], r[14:13], 3'h1});
      rg(8'h2e, {5'h00, r[16:15], 1'b0});
      scr_x <= 11'h064;
      scr_y <= 11'h0c8 + {5'h00, r[11:6] & {r[0], 5'h1f}};
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("addr", exp_addr(r), {cursor_addr_b0, cursor_addr_b1});
      chk("icon_addr", exp_icon(r), {icon_addr_b0, icon_addr_b1});
      @(posedge pclk);
    end
    $display("address test done");
    stop_test(1'b0);
  end
endmodule : hwcur_ctrl_tb
`default_nettype wire

// ### verification/hwcur_host.sv
// Host CPU model driving the APB register port
`timescale 1ns/100ps
`default_nettype none
module hwcur_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 100 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
      hwcur_ctrl_tb.stop_test(1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : hwcur_host
`default_nettype wire
